// [pkg/acc_xfer_pkg.sv]
// Constants and types shared by the accumulator transfer execute logic
package acc_xfer_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int NIB_W   = 4;
  localparam int INSN_W  = 10;
  localparam int PTR_W   = 3;
  localparam int WIDE_W  = 8;
  localparam int REGA_W  = 3;

  // ----------------------------------------------------------------
  // Instruction words
  // ----------------------------------------------------------------
  localparam logic [9:0] OPC_COPY_SECOND = 10'h00E;
  localparam logic [9:0] OPC_COPY_PTR    = 10'h029;
  localparam logic [9:0] OPC_LOAD_WIDE   = 10'h01A;
  localparam logic [9:0] OPC_LOAD_IRQ1   = 10'h217;
  localparam logic [9:0] OPC_LOAD_WK0    = 10'h21B;
  localparam logic [9:0] OPC_LOAD_WK1    = 10'h214;
  localparam logic [9:0] OPC_LOAD_WK2    = 10'h215;
  localparam logic [5:0] OPC_STORE_HI    = 6'h2B;
  localparam int         STORE_IMM_LSB   = 0;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int INSN_CYCLES = 1;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [3:0] RST_NIB  = 4'h0;
  localparam logic [2:0] RST_PTR  = 3'h0;
  localparam logic [7:0] RST_WIDE = 8'h00;

  // ----------------------------------------------------------------
  // Register port indices
  // ----------------------------------------------------------------
  localparam logic [2:0] RA_SECOND  = 3'h0;
  localparam logic [2:0] RA_PTR     = 3'h1;
  localparam logic [2:0] RA_WIDE_LO = 3'h2;
  localparam logic [2:0] RA_WIDE_HI = 3'h3;
  localparam logic [2:0] RA_IRQ1    = 3'h4;
  localparam logic [2:0] RA_WK0     = 3'h5;
  localparam logic [2:0] RA_WK1     = 3'h6;
  localparam logic [2:0] RA_WK2     = 3'h7;

  // ----------------------------------------------------------------
  // Decoded operation, one-hot
  // ----------------------------------------------------------------
  typedef enum logic [8:0] {
    OP_NONE   = 9'h001,
    OP_SECOND = 9'h002,
    OP_PTR    = 9'h004,
    OP_WIDE   = 9'h008,
    OP_IRQ1   = 9'h010,
    OP_WK0    = 9'h020,
    OP_WK1    = 9'h040,
    OP_WK2    = 9'h080,
    OP_STORE  = 9'h100
  } xfer_op_t;

endpackage

// [pkg/xfer_decode_if.sv]
// Decoded instruction carried from the decoder to the execute logic
`timescale 1ns/100ps
interface xfer_decode_if;
  import acc_xfer_pkg::*;

  logic [9:0] insn;
  logic       valid;
  xfer_op_t   op;
  logic [3:0] imm;

  modport decoder (input insn, input valid, output op, output imm);
  modport exec    (output insn, output valid, input op, input imm);
endinterface

// [hdl/xfer_decoder.sv]
// Opcode decoder for the accumulator-source transfer group
`timescale 1ns/100ps
module xfer_decoder
  import acc_xfer_pkg::*;
(
  xfer_decode_if.decoder dec
);

  function automatic logic is_op(input logic [9:0] w, input logic [9:0] opc);
    is_op = (w == opc);
  endfunction

  always_comb begin
    dec.imm = dec.insn[STORE_IMM_LSB +: 4];
    dec.op  = OP_NONE;
    if (dec.valid) begin
      if (is_op(dec.insn, OPC_COPY_SECOND)) begin
        dec.op = OP_SECOND;
      end else if (is_op(dec.insn, OPC_COPY_PTR)) begin
        dec.op = OP_PTR;
      end else if (is_op(dec.insn, OPC_LOAD_WIDE)) begin
        dec.op = OP_WIDE;
      end else if (is_op(dec.insn, OPC_LOAD_IRQ1)) begin
        dec.op = OP_IRQ1;
      end else if (is_op(dec.insn, OPC_LOAD_WK0)) begin
        dec.op = OP_WK0;
      end else if (is_op(dec.insn, OPC_LOAD_WK1)) begin
        dec.op = OP_WK1;
      end else if (is_op(dec.insn, OPC_LOAD_WK2)) begin
        dec.op = OP_WK2;
      end else if (dec.insn[9:4] == OPC_STORE_HI) begin
        dec.op = OP_STORE;
      end
    end
  end

endmodule

// [hdl/accumulator_transfer_ops.sv]
// Execute logic for the accumulator-source transfer instructions
// Overview of operation
// [RULE1] Copy-to-second-register copies the accumulator into the second work register in one cycle.
// [RULE2] Copy-to-pointer loads only accumulator bits 2..0 into the 3-bit pointer register.
// [RULE3] Load-wide-pair puts the second register in the high nibble and the accumulator in the low nibble of E.
// [RULE4] Load-interrupt-control copies the accumulator into interrupt control register one in one cycle.
// [RULE5] First wakeup load copies the accumulator into the first key-on wakeup control register.
// [RULE6] Second wakeup load copies the accumulator into the second key-on wakeup control register.
// [RULE7] Third wakeup load copies the accumulator into the third key-on wakeup control register.
// [RULE8] Store-to-memory writes the accumulator to the nibble addressed by the data pointer.
// [RULE9] Store-to-memory also replaces X with X exclusive-or the immediate in the low opcode bits.
// [RULE10] None of these instructions touch carry, request a skip or change the accumulator.
//
// Design decisions made here: the register addresses and strobed register access.
`timescale 1ns/100ps
module accumulator_transfer_ops
  import acc_xfer_pkg::*;
#(
  parameter int DP_W = 6
)(
  input  wire logic            clk,
  input  wire logic            reset,
  input  wire logic            instr_valid,
  input  wire logic [9:0]      instr_word,
  input  wire logic [3:0]      acc_in,
  input  wire logic [3:0]      x_in,
  input  wire logic [DP_W-1:0] data_pointer,
  input  wire logic [2:0]      reg_addr,
  input  wire logic [3:0]      reg_wdata,
  input  wire logic            reg_wr,
  input  wire logic            reg_rd,
  output logic      [3:0]      reg_rdata,
  output logic      [3:0]      second_reg,
  output logic      [2:0]      ptr_reg,
  output logic      [7:0]      wide_reg,
  output logic      [3:0]      irq_control_one,
  output logic      [3:0]      wakeup_ctrl_first,
  output logic      [3:0]      wakeup_ctrl_second,
  output logic      [3:0]      wakeup_ctrl_third,
  output logic                 mem_we,
  output logic      [DP_W-1:0] mem_addr,
  output logic      [3:0]      mem_wdata,
  output logic                 x_we,
  output logic      [3:0]      x_wdata,
  output logic                 acc_we,
  output logic                 carry_we,
  output logic                 skip_req
);

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  xfer_decode_if dec_bus ();

  assign dec_bus.insn  = instr_word;
  assign dec_bus.valid = instr_valid;

  xfer_decoder u_decoder (
    .dec (dec_bus.decoder)
  );

  xfer_op_t   op;
  logic [3:0] imm;

  assign op  = dec_bus.op;
  assign imm = dec_bus.imm;

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [3:0]      second_reg_reg, second_reg_next;
  logic [2:0]      ptr_reg_reg,    ptr_reg_next;
  logic [7:0]      wide_reg_reg,   wide_reg_next;
  logic [3:0]      irq1_reg,       irq1_next;
  logic [3:0]      wk0_reg,        wk0_next;
  logic [3:0]      wk1_reg,        wk1_next;
  logic [3:0]      wk2_reg,        wk2_next;

  // Software write to a register index, whatever the instruction; the case below overrides it
  function automatic logic sw_hit(input logic wr, input logic [2:0] a, input logic [2:0] idx);
    sw_hit = wr && (a == idx);
  endfunction

  always_comb begin
    second_reg_next = second_reg_reg;
    ptr_reg_next    = ptr_reg_reg;
    wide_reg_next   = wide_reg_reg;
    irq1_next       = irq1_reg;
    wk0_next        = wk0_reg;
    wk1_next        = wk1_reg;
    wk2_next        = wk2_reg;
    // Port writes first so that an instruction in the same cycle wins
    if (sw_hit(reg_wr, reg_addr, RA_SECOND)) begin
      second_reg_next = reg_wdata;
    end
    if (sw_hit(reg_wr, reg_addr, RA_PTR)) begin
      ptr_reg_next = reg_wdata[PTR_W-1:0];
    end
    if (sw_hit(reg_wr, reg_addr, RA_WIDE_LO)) begin
      wide_reg_next[3:0] = reg_wdata;
    end
    if (sw_hit(reg_wr, reg_addr, RA_WIDE_HI)) begin
      wide_reg_next[7:4] = reg_wdata;
    end
    if (sw_hit(reg_wr, reg_addr, RA_IRQ1)) begin
      irq1_next = reg_wdata;
    end
    if (sw_hit(reg_wr, reg_addr, RA_WK0)) begin
      wk0_next = reg_wdata;
    end
    if (sw_hit(reg_wr, reg_addr, RA_WK1)) begin
      wk1_next = reg_wdata;
    end
    if (sw_hit(reg_wr, reg_addr, RA_WK2)) begin
      wk2_next = reg_wdata;
    end
    case (op)
      // [RULE1] second register load
      OP_SECOND: begin
        second_reg_next = acc_in;
      end
      // [RULE2] low three bits only
      OP_PTR: begin
        ptr_reg_next = acc_in[PTR_W-1:0];
      end
      // [RULE3] second register high, accumulator low
      OP_WIDE: begin
        wide_reg_next = {second_reg_reg, acc_in};
      end
      // [RULE4] interrupt control load
      OP_IRQ1: begin
        irq1_next = acc_in;
      end
      // [RULE5] first wakeup load
      OP_WK0: begin
        wk0_next = acc_in;
      end
      // [RULE6] second wakeup load
      OP_WK1: begin
        wk1_next = acc_in;
      end
      // [RULE7] third wakeup load
      OP_WK2: begin
        wk2_next = acc_in;
      end
      default: begin
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      second_reg_reg <= RST_NIB;
      ptr_reg_reg    <= RST_PTR;
      wide_reg_reg   <= RST_WIDE;
      irq1_reg       <= RST_NIB;
      wk0_reg        <= RST_NIB;
      wk1_reg        <= RST_NIB;
      wk2_reg        <= RST_NIB;
    end else begin
      second_reg_reg <= second_reg_next;
      ptr_reg_reg    <= ptr_reg_next;
      wide_reg_reg   <= wide_reg_next;
      irq1_reg       <= irq1_next;
      wk0_reg        <= wk0_next;
      wk1_reg        <= wk1_next;
      wk2_reg        <= wk2_next;
    end
  end

  assign second_reg         = second_reg_reg;
  assign ptr_reg            = ptr_reg_reg;
  assign wide_reg           = wide_reg_reg;
  assign irq_control_one    = irq1_reg;
  assign wakeup_ctrl_first  = wk0_reg;
  assign wakeup_ctrl_second = wk1_reg;
  assign wakeup_ctrl_third  = wk2_reg;

  // ----------------------------------------------------------------
  // Memory store and X update
  // ----------------------------------------------------------------
  logic            mem_we_reg,    mem_we_next;
  logic [DP_W-1:0] mem_addr_reg,  mem_addr_next;
  logic [3:0]      mem_wdata_reg, mem_wdata_next;
  logic            x_we_reg,      x_we_next;
  logic [3:0]      x_wdata_reg,   x_wdata_next;

  always_comb begin
    mem_we_next    = 1'b0;
    mem_addr_next  = mem_addr_reg;
    mem_wdata_next = mem_wdata_reg;
    x_we_next      = 1'b0;
    x_wdata_next   = x_wdata_reg;
    if (op == OP_STORE) begin
      // [RULE8] accumulator to memory at data pointer
      mem_we_next    = 1'b1;
      mem_addr_next  = data_pointer;
      mem_wdata_next = acc_in;
      // [RULE9] X takes X xor immediate
      x_we_next      = 1'b1;
      x_wdata_next   = x_in ^ imm;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      mem_we_reg    <= 1'b0;
      mem_addr_reg  <= '0;
      mem_wdata_reg <= RST_NIB;
      x_we_reg      <= 1'b0;
      x_wdata_reg   <= RST_NIB;
    end else begin
      mem_we_reg    <= mem_we_next;
      mem_addr_reg  <= mem_addr_next;
      mem_wdata_reg <= mem_wdata_next;
      x_we_reg      <= x_we_next;
      x_wdata_reg   <= x_wdata_next;
    end
  end

  assign mem_we    = mem_we_reg;
  assign mem_addr  = mem_addr_reg;
  assign mem_wdata = mem_wdata_reg;
  assign x_we      = x_we_reg;
  assign x_wdata   = x_wdata_reg;

  // ----------------------------------------------------------------
  // Side effects held off and register read port
  // ----------------------------------------------------------------
  logic       side_reg;
  logic [3:0] rdata_reg, rdata_next;

  always_comb begin
    rdata_next = 4'h0;
    if (reg_rd) begin
      case (reg_addr)
        RA_SECOND:  rdata_next = second_reg_reg;
        RA_PTR:     rdata_next = {1'b0, ptr_reg_reg};
        RA_WIDE_LO: rdata_next = wide_reg_reg[3:0];
        RA_WIDE_HI: rdata_next = wide_reg_reg[7:4];
        RA_IRQ1:    rdata_next = irq1_reg;
        RA_WK0:     rdata_next = wk0_reg;
        RA_WK1:     rdata_next = wk1_reg;
        RA_WK2:     rdata_next = wk2_reg;
        default:    rdata_next = 4'h0;
      endcase
    end
  end

  // [RULE10] no carry, skip or accumulator write from this group
  always_ff @(posedge clk) begin
    if (reset) begin
      side_reg  <= 1'b0;
      rdata_reg <= 4'h0;
    end else begin
      side_reg  <= 1'b0;
      rdata_reg <= rdata_next;
    end
  end

  assign acc_we    = side_reg;
  assign carry_we  = side_reg;
  assign skip_req  = side_reg;
  assign reg_rdata = rdata_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  second_load_a : assert property ((op == OP_SECOND) |=> (second_reg == $past(acc_in))) // [RULE1]
    else $error("second register not loaded from accumulator");

  ptr_load_a : assert property ((op == OP_PTR) |=> (ptr_reg == $past(acc_in[2:0]))) // [RULE2]
    else $error("pointer register not loaded from low accumulator bits");

  wide_pair_a : assert property ((op == OP_WIDE) |=> (wide_reg == {$past(second_reg), $past(acc_in)})) // [RULE3]
    else $error("wide register pair load wrong");

  irq_ctrl_a : assert property ((op == OP_IRQ1) |=> (irq_control_one == $past(acc_in))) // [RULE4]
    else $error("interrupt control one not loaded");

  wake_first_a : assert property ((op == OP_WK0) |=> (wakeup_ctrl_first == $past(acc_in))) // [RULE5]
    else $error("first wakeup control not loaded");

  wake_second_a : assert property ((op == OP_WK1) |=> (wakeup_ctrl_second == $past(acc_in))) // [RULE6]
    else $error("second wakeup control not loaded");

  wake_third_a : assert property ((op == OP_WK2) |=> (wakeup_ctrl_third == $past(acc_in))) // [RULE7]
    else $error("third wakeup control not loaded");

  mem_store_a : assert property ((op == OP_STORE) |=> (mem_we && (mem_addr == $past(data_pointer))
                                 && (mem_wdata == $past(acc_in))) ##1 (!mem_we || $past(op == OP_STORE))) // [RULE8]
    else $error("memory store missing or wrong");

  x_update_a : assert property ((op == OP_STORE) |=> x_we && (x_wdata == ($past(x_in) ^ $past(instr_word[3:0])))) // [RULE9]
    else $error("X exclusive-or update wrong");

  store_only_a : assert property ((mem_we || x_we) |-> (mem_we && x_we && $past(op == OP_STORE))) // [RULE8]
    else $error("store strobes without a store instruction");

  no_side_a : assert property (!acc_we && !carry_we && !skip_req) // [RULE10]
    else $error("carry, skip or accumulator disturbed");

endmodule

// [verif/fetch_model.sv]
// Behavioural model of the fetch path that feeds instruction words and operands
`timescale 1ns/100ps
module fetch_model #(
  parameter int DP_W = 6
)(
  output logic            instr_valid,
  output logic [9:0]      instr_word,
  output logic [3:0]      acc_in,
  output logic [3:0]      x_in,
  output logic [DP_W-1:0] data_pointer
);
  initial begin
    instr_valid = 1'b0;
    instr_word = 10'h3FF;
    acc_in = 4'hF;
    x_in = 4'hF;
    data_pointer = '1;
  end

  // ----------------------------------------------------------------
  // Issue one word per cycle
  // ----------------------------------------------------------------
  // Idle cycles flip the operands so nothing stale can pass for a real word
  task automatic drive(input logic v, input logic [9:0] w, input logic [3:0] a, input logic [3:0] x,
                       input logic [DP_W-1:0] p);
    instr_valid <= v;
    instr_word <= v ? w : ~instr_word;
    acc_in <= v ? a : ~acc_in;
    x_in <= v ? x : ~x_in;
    data_pointer <= v ? p : ~data_pointer;
  endtask
endmodule

// [verif/tb.sv]
// Self-checking bench for the accumulator transfer execute logic
`timescale 1ns/100ps
module tb;
  import acc_xfer_pkg::*;
  localparam int DP = 6;
  logic clk, reset, reg_wr, reg_rd, st_flag, st_due, rd_due;
  logic [2:0] reg_addr;
  logic [3:0] reg_wdata, reg_rdata, second_reg, irq_control_one, acc_in, x_in, mem_wdata, x_wdata;
  logic [3:0] wakeup_ctrl_first, wakeup_ctrl_second, wakeup_ctrl_third;
  logic [2:0] ptr_reg;
  logic [7:0] wide_reg;
  logic [9:0] instr_word;
  logic [DP-1:0] data_pointer, mem_addr;
  logic instr_valid, mem_we, x_we, acc_we, carry_we, skip_req;
  int bad_count, n_checks, cycles, seed;
  logic [3:0] m_sec, m_irq, m_wk0, m_wk1, m_wk2;
  logic [2:0] m_ptr;
  logic [7:0] m_wide;
  logic [33:0] q_st[$];
  logic [14:0] q_mem[$];
  logic [3:0] q_rd[$];
  logic [9:0] ops[9] = '{OPC_COPY_SECOND, OPC_COPY_PTR, OPC_LOAD_WIDE, OPC_LOAD_IRQ1, OPC_LOAD_WK0,
                         OPC_LOAD_WK1, OPC_LOAD_WK2, 10'h000, 10'h3FF};

  fetch_model #(.DP_W(DP)) u_fetch (.instr_valid, .instr_word, .acc_in, .x_in, .data_pointer);

  accumulator_transfer_ops #(.DP_W(DP)) u_dut (.clk, .reset, .instr_valid, .instr_word, .acc_in, .x_in,
    .data_pointer, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .second_reg, .ptr_reg, .wide_reg,
    .irq_control_one, .wakeup_ctrl_first, .wakeup_ctrl_second, .wakeup_ctrl_third, .mem_we, .mem_addr,
    .mem_wdata, .x_we, .x_wdata, .acc_we, .carry_we, .skip_req);

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  function automatic logic [3:0] rdval(input logic [2:0] ad);
    case (ad)
      3'h0: return m_sec;
      3'h1: return {1'b0, m_ptr};
      3'h2: return m_wide[3:0];
      3'h3: return m_wide[7:4];
      3'h4: return m_irq;
      3'h5: return m_wk0;
      3'h6: return m_wk1;
      default: return m_wk2;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Driver: one cycle of stimulus plus its expected results
  // ----------------------------------------------------------------
  task automatic cyc(input logic v, input logic [9:0] w, input logic [3:0] a, input logic wr, input logic rd,
                     input logic [2:0] ad, input logic [3:0] wd);
    logic [3:0] x;
    logic [DP-1:0] p;
    logic [3:0] s;
    @(posedge clk);
    x = 4'($urandom);
    p = DP'($urandom);
    s = m_sec;
    u_fetch.drive(v, w, a, x, p);
    reg_wr <= wr;
    reg_rd <= rd;
    reg_addr <= ad;
    reg_wdata <= wd;
    st_flag <= v | wr;
    // Port write first: an instruction in the same cycle overrides it
    if (wr) begin
      case (ad)
        3'h0: m_sec = wd;
        3'h1: m_ptr = wd[2:0];
        3'h2: m_wide[3:0] = wd;
        3'h3: m_wide[7:4] = wd;
        3'h4: m_irq = wd;
        3'h5: m_wk0 = wd;
        3'h6: m_wk1 = wd;
        default: m_wk2 = wd;
      endcase
    end
    if (v) begin
      case (w)
        OPC_COPY_SECOND: m_sec = a;
        OPC_COPY_PTR: m_ptr = a[2:0];
        OPC_LOAD_WIDE: m_wide = {s, a};
        OPC_LOAD_IRQ1: m_irq = a;
        OPC_LOAD_WK0: m_wk0 = a;
        OPC_LOAD_WK1: m_wk1 = a;
        OPC_LOAD_WK2: m_wk2 = a;
        default: if (w[9:4] == OPC_STORE_HI) q_mem.push_back({p, a, 1'b1, x ^ w[3:0]});
      endcase
    end
    if (v | wr) q_st.push_back({m_sec, m_ptr, m_wide, m_irq, m_wk0, m_wk1, m_wk2, 3'h0});
    if (rd) q_rd.push_back(rdval(ad));
  endtask

  task automatic check(input logic [63:0] e, input logic [63:0] g);
    n_checks++;
    if (g !== e) begin
      $display("ERROR t=%0t exp=%h got=%h", $time, e, g);
      bad_count++;
    end
  endtask

  task automatic results();
    if (q_mem.size() != 0) bad_count++;
    if (bad_count == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Monitor: takes the oldest note when a result appears
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    st_due <= st_flag;
    rd_due <= reg_rd;
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      bad_count++;
      results();
    end
  end

  always @(negedge clk) begin
    if (st_due === 1'b1)
      check(64'(q_st.pop_front()), 64'({second_reg, ptr_reg, wide_reg, irq_control_one, wakeup_ctrl_first,
            wakeup_ctrl_second, wakeup_ctrl_third,
            acc_we, carry_we, skip_req}));
    if (rd_due === 1'b1)
      check(64'(q_rd.pop_front()), 64'(reg_rdata));
    if (mem_we === 1'b1) begin
      if (q_mem.size() == 0)
        check(64'h0, 64'h1);
      else
        check(64'(q_mem.pop_front()), 64'({mem_addr, mem_wdata, x_we, x_wdata}));
    end else begin
      check(64'h0, 64'(x_we));
    end
  end

  initial begin
    reset = 1'b1;
    {reg_wr, reg_rd, st_flag, st_due, rd_due} = 5'h00;
    reg_addr = 3'h0;
    reg_wdata = 4'h0;
    {m_sec, m_irq, m_wk0, m_wk1, m_wk2, m_ptr, m_wide} = 31'h0;
    bad_count = 0;
    n_checks = 0;
    cycles = 0;
    seed = $urandom(53);
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    cyc(0, 10'h0, 4'h0, 0, 0, 3'h0, 4'h0);
    // Reset values of every register, read back to back
    for (int a = 0; a < 8; a++) cyc(0, 10'h0, 4'h0, 0, 1, 3'(a), 4'h0);
    // Every opcode except store back to back, two foreign words among them
    repeat (3) foreach (ops[i]) cyc(1, ops[i], 4'($urandom), 0, 0, 3'h0, 4'h0);
    // Port write colliding with an instruction in the same cycle
    repeat (3) foreach (ops[i]) cyc(1, ops[i], 4'($urandom), 1, 0, 3'($urandom), 4'($urandom));
    // Store across all immediates
    for (int j = 0; j < 16; j++) cyc(1, {OPC_STORE_HI, 4'(j)}, 4'($urandom), 0, 0, 3'h0, 4'h0);
    for (int a = 0; a < 8; a++) cyc(0, 10'h0, 4'h0, 1, 0, 3'(a), 4'($urandom));
    for (int a = 0; a < 8; a++) cyc(0, 10'h0, 4'h0, 0, 1, 3'(a), 4'h0);
    // Mixed traffic with bit 3 of the accumulator exercised on the pointer load
    repeat (80) begin
      case ($urandom % 4)
        0: cyc(1, ops[$urandom % 9], 4'($urandom), 0, 0, 3'h0, 4'h0);
        1: cyc(1, {OPC_STORE_HI, 4'($urandom)}, 4'($urandom), 0, 0, 3'h0, 4'h0);
        2: cyc(0, 10'h0, 4'h0, 1, 0, 3'($urandom), 4'($urandom));
        default: cyc(0, 10'h0, 4'h0, 0, 1, 3'($urandom), 4'h0);
      endcase
    end
    repeat (3) cyc(0, 10'h0, 4'h0, 0, 0, 3'h0, 4'h0);
    results();
  end
endmodule
